// file: hdl/fifo_split_pkg.sv
// Constants for the display FIFO split and watermark block
// Contract
// - Split one shared RAM into three plane FIFOs
// - Split double buffered, loaded at vblank start
// - Deep-sleep single plane mode takes whole RAM
// - 64-byte units, 96 or 128 units total
// - Sizes from B and C boundaries
// - Auto-sizing variant reserves the split register
// - Split resets to 00001D9C
// - Watermarks only in high-resolution mode
// - Self-refresh watermark used in deep sleep
// - Plane A and B watermarks gate requests
// - Second cursor watermark gates its requests
// - First cursor watermark gates its requests
// - Second sprite watermark gates its requests
// - Compressed-buffer self-refresh watermark fields
package fifo_split_pkg;
    localparam logic [19:0] split_offset = 20'h70030;
    localparam logic [19:0] wm_one_offset = 20'h70034;
    localparam logic [19:0] wm_two_offset = 20'h70038;
    localparam logic [31:0] split_reset = 32'h00001D9C;
    localparam logic [31:0] wm_one_reset = 32'h3F8F0F0F;
    localparam logic [31:0] wm_two_reset = 32'h00000F0F;
    localparam logic [31:0] split_mask = 32'h00003FFF;
    localparam logic [31:0] wm_one_mask = 32'hFFBF7F7F;
    localparam logic [31:0] wm_two_mask = 32'hFF7F3F7F;
    localparam int b_bound_lsb = 0;
    localparam int c_bound_lsb = 7;
    localparam int bound_width = 7;
    localparam int wm_a_lsb = 0;
    localparam int wm_b_lsb = 8;
    localparam int wm_cur2_lsb = 16;
    localparam int wm_sr_lsb = 23;
    localparam int wm_cur1_lsb = 8;
    localparam int wm_spr2_lsb = 16;
    localparam int cb_srhp_lsb = 24;
    localparam int cb_sr_lsb = 28;
    localparam int cb_en_bit = 31;
    localparam int unit_bytes = 64;
    localparam int total_units_default = 128;
endpackage

// file: hdl/display_fifo_partition.sv
// Display FIFO partition and watermark request logic with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module display_fifo_partition #(
    parameter int total_units = fifo_split_pkg::total_units_default,
    parameter bit auto_size = 1'b0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Display pipe status
    input wire logic vblank_start,
    input wire logic deep_sleep_state,
    input wire logic hires_mode,
    input wire logic plane_a_on,
    input wire logic plane_b_on,
    // Free space per stream, in 64-byte units
    input wire logic [7:0] free_a,
    input wire logic [7:0] free_b,
    input wire logic [7:0] free_c,
    input wire logic [7:0] free_cur1,
    input wire logic [7:0] free_cur2,
    input wire logic [7:0] free_spr2,
    // Active FIFO sizes in 64-byte units
    output logic [7:0] size_a,
    output logic [7:0] size_b,
    output logic [7:0] size_c,
    // Requests to memory
    output logic req_a,
    output logic req_b,
    output logic req_c,
    output logic req_cur1,
    output logic req_cur2,
    output logic req_spr2
);
    // Only the two RAM sizes that the split logic knows are accepted
    if (total_units != 96 && total_units != 128) begin : g_bad_total
        $error("total_units must be 96 or 128");
    end

    localparam logic [7:0] tot = 8'(total_units);

    logic [31:0] split_reg;
    logic [31:0] split_act_reg;
    logic [31:0] wm_one_reg;
    logic [31:0] wm_two_reg;
    logic wr_pend_reg;
    logic [19:0] addr_reg;
    logic [7:0] req_reg;

    // Address phase capture; all transfers complete with no wait
    wire logic take = hsel && hready && htrans[1];
    wire logic wr_take = take && hwrite;
    wire logic hit_split = addr_reg == fifo_split_pkg::split_offset;
    wire logic hit_one = addr_reg == fifo_split_pkg::wm_one_offset;
    wire logic hit_two = addr_reg == fifo_split_pkg::wm_two_offset;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 20'h00000;
        end else if (hready) begin
            wr_pend_reg <= wr_take;
            addr_reg <= take ? haddr[19:0] : 20'hFFFFF;
        end
    end

    // Read mux; reserved bits are masked, unmapped reads return zero
    wire logic [31:0] rd_split = auto_size ? 32'h00000000 : split_reg;
    wire logic [31:0] rd_next = hit_split ? rd_split :
        hit_one ? wm_one_reg : hit_two ? wm_two_reg : 32'h00000000;
    assign hrdata = rd_next;

    // Register writes; masked bits
    // reset value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            split_reg <= fifo_split_pkg::split_reset;
            wm_one_reg <= fifo_split_pkg::wm_one_reset;
            wm_two_reg <= fifo_split_pkg::wm_two_reset;
        end else if (wr_pend_reg) begin
            // split writes ignored when auto sized
            if (hit_split && !auto_size) begin
                split_reg <= hwdata & fifo_split_pkg::split_mask;
            end
            if (hit_one) begin
                wm_one_reg <= hwdata & fifo_split_pkg::wm_one_mask;
            end
            if (hit_two) begin
                wm_two_reg <= hwdata & fifo_split_pkg::wm_two_mask;
            end
        end
    end

    // active copy loads at vblank start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            split_act_reg <= fifo_split_pkg::split_reset;
        end else if (vblank_start) begin
            split_act_reg <= split_reg;
        end
    end

    wire logic [7:0] b_bound = {1'b0,
        split_act_reg[fifo_split_pkg::b_bound_lsb +: 7]};
    wire logic [7:0] c_bound = {1'b0,
        split_act_reg[fifo_split_pkg::c_bound_lsb +: 7]};
    // single plane in deep sleep takes the whole RAM
    wire logic solo_a = deep_sleep_state && plane_a_on && !plane_b_on;
    wire logic solo_b = deep_sleep_state && plane_b_on && !plane_a_on;
    // Auto sizing gives A and B a third each, C takes the remainder
    wire logic [7:0] third = 8'(total_units / 3);

    wire logic [7:0] sz_a = solo_a ? tot : solo_b ? 8'h00 :
        auto_size ? third : b_bound;
    wire logic [7:0] sz_b = solo_b ? tot : solo_a ? 8'h00 :
        auto_size ? third : 8'(c_bound - b_bound);
    wire logic [7:0] sz_c = (solo_a || solo_b) ? 8'h00 :
        auto_size ? 8'(tot - 8'(2 * (total_units / 3))) :
        8'(tot - c_bound - 8'h01);
    assign size_a = sz_a;
    assign size_b = sz_b;
    assign size_c = sz_c;

    // Watermark fields
    wire logic [7:0] wm_a = {1'b0, wm_one_reg[fifo_split_pkg::wm_a_lsb +: 7]};
    wire logic [7:0] wm_b = {1'b0, wm_one_reg[fifo_split_pkg::wm_b_lsb +: 7]};
    wire logic [8:0] wm_sr = wm_one_reg[fifo_split_pkg::wm_sr_lsb +: 9];
    wire logic [7:0] wm_c2 = {2'b00,
        wm_one_reg[fifo_split_pkg::wm_cur2_lsb +: 6]};
    wire logic [7:0] wm_c1 = {2'b00,
        wm_two_reg[fifo_split_pkg::wm_cur1_lsb +: 6]};
    wire logic [7:0] wm_s2 = {1'b0,
        wm_two_reg[fifo_split_pkg::wm_spr2_lsb +: 7]};
    // compressed-buffer fields, lines not translated to units here
    wire logic cb_en = wm_two_reg[fifo_split_pkg::cb_en_bit];
    wire logic [2:0] cb_sr = wm_two_reg[fifo_split_pkg::cb_sr_lsb +: 3];
    wire logic [3:0] cb_srhp = wm_two_reg[fifo_split_pkg::cb_srhp_lsb +: 4];
    wire logic sr = deep_sleep_state;

    // self refresh watermark replaces plane watermarks; plane C takes cb_srhp instead when cb_en is set
    wire logic [8:0] thr_a = sr ? wm_sr : {1'b0, wm_a};
    wire logic [8:0] thr_b = sr ? wm_sr : {1'b0, wm_b};
    wire logic [8:0] thr_c = sr ? (cb_en ? {5'h00, cb_srhp} : wm_sr) :
        {1'b0, wm_b} + {6'h00, cb_sr & {3{cb_en}}};

    wire logic [7:0] req_next = {2'b00,
        {1'b0, free_spr2} > {1'b0, wm_s2},
        {1'b0, free_cur2} > {1'b0, wm_c2},
        {1'b0, free_cur1} > {1'b0, wm_c1},
        {1'b0, free_c} > thr_c,
        {1'b0, free_b} > thr_b,
        {1'b0, free_a} > thr_a} & {8{hires_mode}};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg <= 8'h00;
        end else begin
            req_reg <= req_next;
        end
    end

    assign req_a = req_reg[0];
    assign req_b = req_reg[1];
    assign req_c = req_reg[2];
    assign req_cur1 = req_reg[3];
    assign req_cur2 = req_reg[4];
    assign req_spr2 = req_reg[5];

    // Checks
    // A split write lands in its data phase
    sequence s_split_wr;
        wr_pend_reg && hit_split && !auto_size;
    endsequence

    // Vertical blank starts in this cycle
    sequence s_vblank;
        vblank_start;
    endsequence

    property p_split_load;
        @(posedge hclk) disable iff (!hresetn)
        vblank_start |=> split_act_reg == $past(split_reg);
    endproperty
    a_split_load: assert property (p_split_load)
        else $error("split not loaded");

    property p_split_hold;
        @(posedge hclk) disable iff (!hresetn)
        !vblank_start |=> $stable(split_act_reg);
    endproperty
    a_split_hold: assert property (p_split_hold)
        else $error("split moved");

    property p_wr_load;
        @(posedge hclk) disable iff (!hresetn)
        s_split_wr ##1 s_vblank |=>
            split_act_reg == ($past(hwdata, 2) & fifo_split_pkg::split_mask);
    endproperty
    a_wr_load: assert property (p_wr_load)
        else $error("written split not made active");

    property p_split_wr;
        @(posedge hclk) disable iff (!hresetn)
        s_split_wr |=>
            split_reg == ($past(hwdata) & fifo_split_pkg::split_mask);
    endproperty
    a_split_wr: assert property (p_split_wr)
        else $error("split write not masked");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        (split_reg & ~fifo_split_pkg::split_mask) == 32'h00000000 &&
            (wm_one_reg & ~fifo_split_pkg::wm_one_mask) == 32'h00000000 &&
            (wm_two_reg & ~fifo_split_pkg::wm_two_mask) == 32'h00000000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");

    property p_req_a;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && !sr && free_a > wm_a) |=> req_a;
    endproperty
    a_req_a: assert property (p_req_a)
        else $error("plane a no request");

    property p_req_b;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && !sr && free_b > wm_b) |=> req_b;
    endproperty
    a_req_b: assert property (p_req_b)
        else $error("plane b no request");

    property p_req_c;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && {1'b0, free_c} > thr_c) |=> req_c;
    endproperty
    a_req_c: assert property (p_req_c)
        else $error("plane c no request");

    property p_req_drop;
        @(posedge hclk) disable iff (!hresetn)
        ({1'b0, free_b} <= thr_b) |=> !req_b;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("plane b stuck");

    property p_sr;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && sr && {1'b0, free_a} > wm_sr) |=> req_a;
    endproperty
    a_sr: assert property (p_sr)
        else $error("self refresh request lost");

    property p_cur;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && free_cur2 > wm_c2) |=> req_cur2;
    endproperty
    a_cur: assert property (p_cur)
        else $error("cursor request lost");

    property p_cur1;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && free_cur1 > wm_c1) |=> req_cur1;
    endproperty
    a_cur1: assert property (p_cur1)
        else $error("first cursor request lost");

    property p_spr2;
        @(posedge hclk) disable iff (!hresetn)
        (hires_mode && free_spr2 > wm_s2) |=> req_spr2;
    endproperty
    a_spr2: assert property (p_spr2)
        else $error("sprite request lost");

    property p_hires;
        @(posedge hclk) disable iff (!hresetn)
        !hires_mode |=> req_reg == 8'h00;
    endproperty
    a_hires: assert property (p_hires)
        else $error("request in vga");

    property p_solo;
        @(posedge hclk) disable iff (!hresetn)
        solo_a |-> size_a == tot && size_b == 8'h00;
    endproperty
    a_solo: assert property (p_solo)
        else $error("solo sizing wrong");

    property p_solo_b;
        @(posedge hclk) disable iff (!hresetn)
        solo_b |-> size_b == tot && size_a == 8'h00 && size_c == 8'h00;
    endproperty
    a_solo_b: assert property (p_solo_b)
        else $error("solo b sizing wrong");

    property p_sum;
        @(posedge hclk) disable iff (!hresetn)
        (!auto_size && !solo_a && !solo_b) |->
            8'(size_a + size_b + size_c + 8'h01) == tot;
    endproperty
    a_sum: assert property (p_sum)
        else $error("sizes do not sum");
endmodule
`default_nettype wire

// file: tb/fetch_memory_model.sv
// Memory side model: fills stream FIFOs on request, display drains them
`timescale 1ns/1ps
`default_nettype none
module fetch_memory_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench command: memory answers slowly
    input wire logic stall,
    // Stream requests and free space in 64-byte units
    input wire logic [5:0] req,
    output logic [47:0] free_bus
);
    logic [7:0] free_reg [6];

    // A granted request lands a 4-unit burst; drain is random to cross marks
    // drain only adds space while it is below 124 units
    // drain idles a quarter of cycles, below clock rate
    always @(posedge hclk or negedge hresetn) begin
        for (int i = 0; i < 6; i++) begin
            if (!hresetn)
                free_reg[i] <= 8'h00;
            else if (req[i] && !stall)
                free_reg[i] <= (free_reg[i] > 8'h03) ?
                    free_reg[i] - 8'h04 : 8'h00;
            else if (free_reg[i] < 8'h7C)
                free_reg[i] <= free_reg[i] + 8'($urandom_range(0, 3));
        end
    end

    // Flatten for the design's free-space ports
    always_comb begin
        for (int i = 0; i < 6; i++)
            free_bus[i*8 +: 8] = free_reg[i];
    end
endmodule
`default_nettype wire

// file: tb/display_fifo_partition_watermark_tb.sv
// Self-checking bench for the display FIFO partition block
`timescale 1ns/1ps
`default_nettype none
module display_fifo_partition_watermark_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic vblank_start = 1'b0, sleep = 1'b0, hires = 1'b1;
    logic a_on = 1'b1, b_on = 1'b1;
    logic stall = 1'b0, mon = 1'b0, mon_v = 1'b0;
    logic [31:0] wm1 = fifo_split_pkg::wm_one_reset;
    logic [31:0] wm2 = fifo_split_pkg::wm_two_reset;
    logic [5:0] exp_q = 6'h00;
    wire hreadyout, hresp;
    wire [31:0] hrdata;
    wire [7:0] size_a, size_b, size_c;
    wire [5:0] req;
    wire [47:0] free;
    int mismatches = 0, n_compared = 0;

    display_fifo_partition #(.total_units(128), .auto_size(1'b0)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .vblank_start(vblank_start), .deep_sleep_state(sleep),
        .hires_mode(hires), .plane_a_on(a_on), .plane_b_on(b_on),
        .free_a(free[7:0]), .free_b(free[15:8]), .free_c(free[23:16]),
        .free_cur1(free[31:24]), .free_cur2(free[39:32]),
        .free_spr2(free[47:40]), .size_a(size_a), .size_b(size_b),
        .size_c(size_c), .req_a(req[0]), .req_b(req[1]), .req_c(req[2]),
        .req_cur1(req[3]), .req_cur2(req[4]), .req_spr2(req[5]));

    fetch_memory_model mem (.hclk(hclk), .hresetn(hresetn), .stall(stall),
        .req(req), .free_bus(free));

    initial forever #2 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for hready; a hung slave ends the run
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic xfer(input logic w, input logic [19:0] a,
        input logic [31:0] d);
        haddr <= {12'h000, a};
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rw(input logic [19:0] a, input logic [31:0] d,
        input logic [31:0] e);
        xfer(1'b1, a, d);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Sizes {c, b, a} for a 128-unit RAM
    function automatic logic [31:0] sizes(input logic [31:0] s);
        logic [7:0] b, c;
        b = {1'b0, s[6:0]};
        c = {1'b0, s[13:7]};
        return {8'h00, 8'h7F - c, c - b, b};
    endfunction

    function automatic logic [5:0] exp_req(input logic [47:0] f,
        input logic s);
        logic [8:0] wa, wb, wc;
        wa = s ? wm1[31:23] : {2'h0, wm1[6:0]};
        wb = s ? wm1[31:23] : {2'h0, wm1[14:8]};
        // Plane C: B mark plus compressed lines, PLL-off field in sleep
        wc = {2'h0, wm1[14:8]} + (wm2[31] ? {6'h00, wm2[30:28]} : 9'h000);
        if (s)
            wc = wm2[31] ? {5'h00, wm2[27:24]} : wm1[31:23];
        return {f[47:40] > wm2[22:16], f[39:32] > wm1[21:16],
            f[31:24] > wm2[13:8], {1'b0, f[23:16]} > wc,
            {1'b0, f[15:8]} > wb, {1'b0, f[7:0]} > wa};
    endfunction

    // Requests registered one cycle after free space; all six streams
    always @(negedge hclk) begin
        if (mon_v)
            chk({26'h0, req}, {26'h0, exp_q});
        mon_v <= mon;
        exp_q <= hires ? exp_req(free, sleep) : 6'h00;
    end

    initial begin
        logic [31:0] sp [4];
        logic [31:0] act;
        int b;
        void'($urandom(32'hB531));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, fifo_split_pkg::wm_one_offset, 32'h0);
        chk(rd, fifo_split_pkg::wm_one_reset);
        xfer(1'b0, fifo_split_pkg::wm_two_offset, 32'h0);
        chk(rd, fifo_split_pkg::wm_two_reset);
        xfer(1'b0, 20'h7003C, 32'h0);
        chk(rd, 32'h0);
        rw(fifo_split_pkg::wm_one_offset, 32'hFFFFFFFF,
            fifo_split_pkg::wm_one_mask);
        act = fifo_split_pkg::split_reset;
        // B boundary never above the unit count
        b = $urandom_range(0, 127);
        // corners: B equals C, B at zero, C at total minus one
        sp = '{32'hFFFFFFFF, 32'h0, 32'h3F80,
            (32'($urandom_range(b, 127)) << 7) | 32'(b)};
        foreach (sp[i]) begin
            xfer(1'b1, fifo_split_pkg::split_offset, sp[i]);
            // one pipe, split takes effect at next vblank
            vblank_start <= 1'b1;
            @(negedge hclk);
            chk({8'h00, size_c, size_b, size_a}, sizes(act));
            act = sp[i] & fifo_split_pkg::split_mask;
            @(posedge hclk);
            vblank_start <= 1'b0;
            @(negedge hclk);
            chk({8'h00, size_c, size_b, size_a}, sizes(act));
            @(posedge hclk);
            xfer(1'b0, fifo_split_pkg::split_offset, 32'h0);
            chk(rd, act);
        end
        // marks kept in the range used for 32bpp
        wm1 = {9'($urandom_range(0, 30)), 1'b0, 6'($urandom_range(0, 12)),
            1'b0, 7'($urandom_range(0, 12)), 1'b0, 7'h08};
        wm2 = {8'($urandom_range(0, 255)), 1'b0, 7'($urandom_range(0, 12)),
            2'h0, 6'h08, 8'h0F};
        rw(fifo_split_pkg::wm_one_offset, wm1, wm1);
        rw(fifo_split_pkg::wm_two_offset, wm2, wm2);
        mon <= 1'b1;
        // Random memory stalls, then low-res, then deep sleep single plane
        repeat (1500) begin
            @(posedge hclk);
            stall <= 1'($urandom_range(0, 1));
        end
        hires <= 1'b0;
        repeat (60) @(posedge hclk);
        hires <= 1'b1;
        b_on <= 1'b0;
        sleep <= 1'b1;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk({24'h0, size_a}, 32'h80);
        repeat (600) begin
            @(posedge hclk);
            stall <= 1'($urandom_range(0, 1));
        end
        // Deep sleep with plane B as the single active plane
        a_on <= 1'b0;
        b_on <= 1'b1;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk({8'h00, size_c, size_b, size_a}, 32'h00008000);
        repeat (300) begin
            @(posedge hclk);
            stall <= 1'($urandom_range(0, 1));
        end
        test_done();
    end
endmodule
`default_nettype wire
